// ---- core/sib_defs.svh ----
// constants for the information block and security access logic
`ifndef SIB_DEFS_SVH
`define SIB_DEFS_SVH

// ----------------------------------------------------------------
// command space addresses
// ----------------------------------------------------------------
`define SIB_ADDR_CTL_LO 8'h00
`define SIB_ADDR_CTL_HI 8'h01
`define SIB_ADDR_SUBCLASS 8'h3e
`define SIB_ADDR_BLOCK 8'h3f
`define SIB_ADDR_WINDOW 8'h40
`define SIB_ADDR_WINDOW_LAST 8'h5f
`define SIB_ADDR_CKSUM 8'h60
`define SIB_ADDR_SELECTOR 8'h61

// ----------------------------------------------------------------
// block geometry and selection codes
// ----------------------------------------------------------------
`define SIB_BLOCK_BYTES 6'h20
`define SIB_INFO_BYTES 8'h60
`define SIB_MAX_BLOCK 8'h03
`define SIB_SEL_GENERAL 8'h00
`define SIB_SEL_INFO 8'h01
`define SIB_SEL_INFO_A 8'h01
`define SIB_SEL_INFO_C 8'h03
`define SIB_INFO_SUBCLASS 8'h39
`define SIB_INFO_A_PAGE 2'h0
`define SIB_INFO_LAST_PAGE 2'h2

// ----------------------------------------------------------------
// key storage page and byte offsets inside it
// ----------------------------------------------------------------
`define SIB_KEY_SUBCLASS 8'h70
`define SIB_KEY_PAGE 10'h1c0
`define SIB_OFS_UNSEAL_K1 5'h00
`define SIB_OFS_UNSEAL_K0 5'h02
`define SIB_OFS_FULL_K1 5'h04
`define SIB_OFS_FULL_K0 5'h06
`define SIB_DEF_UNSEAL_K1 16'h0414
`define SIB_DEF_UNSEAL_K0 16'h3672
`define SIB_DEF_FULL_K1 16'hffff
`define SIB_DEF_FULL_K0 16'hfffe

// ----------------------------------------------------------------
// control port subcommand and status word bits
// ----------------------------------------------------------------
`define SIB_CMD_SEAL 16'h0020
`define SIB_STAT_SEALED 13
`define SIB_STAT_FULL 14

`endif

// ---- core/sib_pkg.sv ----
// types shared by the information block and security access logic
package sib_pkg;

  typedef enum logic [1:0] {
    SIB_FULL = 2'b00,
    SIB_OPEN = 2'b01,
    SIB_SEALED = 2'b10
  } sib_level_t;

  typedef logic [9:0] sib_page_t;

endpackage

// ---- core/sib_keychk.sv ----
// detector for one two-word key sequence on the control port
`timescale 1ns/1ns
`default_nettype none

module sib_keychk (
  input wire logic mclk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic word_valid, // one-cycle pulse, a control word arrived
  input wire logic [15:0] word, // control word as received
  input wire logic [15:0] key_first, // expected first word
  input wire logic [15:0] key_second, // expected second word
  output logic match // one-cycle pulse, pair seen back to back
);

  logic got_first;

  // every control word re-arms or drops the first half, so any other
  // word between the two keys breaks the pair
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      got_first <= 1'b0;
    end else if (word_valid) begin
      got_first <= (word == key_first);
    end
  end

  assign match = word_valid && got_first && (word == key_second);

endmodule

`default_nettype wire

// ---- core/sib_nvm.sv ----
// non-volatile page store, one 32-byte row per subclass block
`timescale 1ns/1ns
`default_nettype none

`include "sib_defs.svh"

module sib_nvm (
  input wire logic mclk, // system clock
  input wire sib_pkg::sib_page_t rd_page, // page to read
  output logic [255:0] rd_row, // contents of rd_page, byte 0 in low bits
  input wire logic wr_en, // commit strobe
  input wire sib_pkg::sib_page_t wr_page, // page to overwrite
  input wire logic [255:0] wr_row, // new page contents
  output logic [255:0] key_row // contents of the key page
);
  import sib_pkg::*;

  localparam logic [15:0] def_unseal_k1 = `SIB_DEF_UNSEAL_K1;
  localparam logic [15:0] def_unseal_k0 = `SIB_DEF_UNSEAL_K0;
  localparam logic [15:0] def_full_k1 = `SIB_DEF_FULL_K1;
  localparam logic [15:0] def_full_k0 = `SIB_DEF_FULL_K0;
  // key words sit high byte first, key 1 of the unseal pair at byte 0
  localparam logic [255:0] key_init = {192'h0,
    def_full_k0[7:0], def_full_k0[15:8],
    def_full_k1[7:0], def_full_k1[15:8],
    def_unseal_k0[7:0], def_unseal_k0[15:8],
    def_unseal_k1[7:0], def_unseal_k1[15:8]};

  // contents survive reset; only power-up sets them, keys to defaults;
  // a declaration value keeps the commit process the only writer
  logic [255:0] mem [0:1023] = '{`SIB_KEY_PAGE: key_init, default: 256'h0};

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_page] <= wr_row;
    end
  end

  assign rd_row = mem[rd_page];
  assign key_row = mem[`SIB_KEY_PAGE];

endmodule

`default_nettype wire

// ---- core/sib_access.sv ----
// information block window, checksum commit and security level control
//
// How it works
// R1: ninety-six bytes of info storage, blocks A, B, C of 32 bytes.
// R2: open level with selector 0 addresses info blocks by subclass and block.
// R3: window contents reach storage only after a verified checksum.
// R4: block B sits in subclass 57 at offsets 32 to 63.
// R5: only subclass and offset form the address; class plays no part.
// R6: sealed or selector nonzero: block code 1..3 loads info A, B or C.
// R7: in that mode an edited info block is written back on good checksum.
// R8: while sealed, info block A is read-only.
// R9: three levels; sealed gives no parameter flash; info always readable.
// R10: only full-access level may rewrite the transition keys.
// R11: host sends each key pair back to back on the control port.
// R12: host keys never equal a defined control subcommand.
// R13: sealed flag stays set while sealed, cleared by the unseal pair.
// R14: full-access flag is cleared by the full-access key pair.
// R15: keys are two-byte words in storage, writable only at full access.
// R16: host sends key word 1 first, then key word 0.
// R17: host byte-swaps each key word relative to its readback form.
// R18: host checksum is 255 minus low byte of the block byte sum.
// R19: selector 1 chooses info block selection, 0 general flash.
// R20: a write longer than the 32-byte block is discarded.
// R21: wrong or interrupted key pair leaves level and flags alone.
// R22: a bad checksum leaves storage alone and keeps the window for retry.
`timescale 1ns/1ns
`default_nettype none

`include "sib_defs.svh"

module sib_access (
  input wire logic mclk, // system clock, 10 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [7:0] cmd_addr, // command code
  input wire logic [7:0] cmd_wdata, // write data
  input wire logic cmd_wr, // write strobe, one cycle
  input wire logic cmd_rd, // read strobe, one cycle
  output logic [7:0] cmd_rdata, // read data, valid the cycle after cmd_rd
  output sib_pkg::sib_level_t security_level, // current security level
  output logic sealed_flag, // status: sealed
  output logic full_access_flag, // status: not in full access
  output logic commit_pulse, // one cycle after a page was committed
  output logic reject_pulse // one cycle after a checksum write was refused
);
  import sib_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sib_level_t level;
  logic [7:0] subclass;
  logic [7:0] block_code;
  logic [7:0] selector;
  logic [7:0] ctl_lo;
  logic [7:0] window [0:31];
  logic [5:0] wr_count;
  sib_page_t page;
  logic page_valid;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_ctl_lo;
  logic wr_ctl_hi;
  logic wr_sub;
  logic wr_blk;
  logic wr_win;
  logic wr_ck;
  logic wr_sel;
  logic rd_win;
  logic general_mode;
  logic [4:0] win_idx;
  logic [4:0] rd_idx;

  assign wr_ctl_lo = cmd_wr && (cmd_addr == `SIB_ADDR_CTL_LO);
  assign wr_ctl_hi = cmd_wr && (cmd_addr == `SIB_ADDR_CTL_HI);
  assign wr_sub = cmd_wr && (cmd_addr == `SIB_ADDR_SUBCLASS);
  assign wr_blk = cmd_wr && (cmd_addr == `SIB_ADDR_BLOCK);
  assign wr_win = cmd_wr && (cmd_addr >= `SIB_ADDR_WINDOW) && (cmd_addr <= `SIB_ADDR_WINDOW_LAST);
  assign wr_ck = cmd_wr && (cmd_addr == `SIB_ADDR_CKSUM);
  assign wr_sel = cmd_wr && (cmd_addr == `SIB_ADDR_SELECTOR);
  assign rd_win = (cmd_addr >= `SIB_ADDR_WINDOW) && (cmd_addr <= `SIB_ADDR_WINDOW_LAST);
  assign win_idx = cmd_addr[4:0];
  assign rd_idx = cmd_addr[4:0];

  // general flash addressing needs an unsealed level and a zero selector
  assign general_mode = (level != SIB_SEALED) && (selector == `SIB_SEL_GENERAL); // see R2 see R19

  // ----------------------------------------------------------------
  // storage and key words
  // ----------------------------------------------------------------
  sib_page_t next_page;
  logic load_ok;
  logic [255:0] rd_row;
  logic [255:0] key_row;
  logic [255:0] win_row;
  logic commit;

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      win_row[i*8 +: 8] = window[i];
    end
  end

  sib_nvm u_nvm (
    .mclk(mclk),
    .rd_page(next_page),
    .rd_row(rd_row),
    .wr_en(commit),
    .wr_page(page),
    .wr_row(win_row),
    .key_row(key_row)
  );

  // key words are stored high byte first; the control port carries them
  // byte-swapped, so the expected word is the stored bytes read low first
  logic [15:0] unseal_k1;
  logic [15:0] unseal_k0;
  logic [15:0] full_k1;
  logic [15:0] full_k0;

  assign unseal_k1 = key_row[`SIB_OFS_UNSEAL_K1*8 +: 16]; // see R15 see R17
  assign unseal_k0 = key_row[`SIB_OFS_UNSEAL_K0*8 +: 16];
  assign full_k1 = key_row[`SIB_OFS_FULL_K1*8 +: 16];
  assign full_k0 = key_row[`SIB_OFS_FULL_K0*8 +: 16];

  // ----------------------------------------------------------------
  // block select: which page is copied into the window
  // ----------------------------------------------------------------
  always_comb begin
    next_page = page;
    load_ok = 1'b0;
    if (wr_blk) begin
      if (general_mode) begin
        // page is subclass and block only; class grouping never enters
        next_page = {subclass, cmd_wdata[1:0]}; // see R2 see R4 see R5
        load_ok = (cmd_wdata <= `SIB_MAX_BLOCK);
      end else if ((cmd_wdata >= `SIB_SEL_INFO_A) && (cmd_wdata <= `SIB_SEL_INFO_C)) begin
        next_page = {`SIB_INFO_SUBCLASS, 2'(cmd_wdata - `SIB_SEL_INFO_A)}; // see R6 see R1
        load_ok = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // write permission and checksum
  // ----------------------------------------------------------------
  logic is_info;
  logic is_info_a;
  logic is_key;
  logic overflow;
  logic page_perm;
  logic [7:0] sum;
  logic cksum_ok;

  assign is_info = (page[9:2] == `SIB_INFO_SUBCLASS) && (page[1:0] <= `SIB_INFO_LAST_PAGE);
  assign is_info_a = is_info && (page[1:0] == `SIB_INFO_A_PAGE);
  assign is_key = (page[9:2] == `SIB_KEY_SUBCLASS);
  assign overflow = (wr_count > `SIB_BLOCK_BYTES); // see R20

  always_comb begin
    page_perm = 1'b0;
    if (page_valid) begin
      if (level == SIB_SEALED) begin
        // sealed: no parameter flash, info A read-only, B and C editable
        page_perm = is_info && !is_info_a; // see R8 see R9
      end else if (is_key) begin
        page_perm = (level == SIB_FULL); // see R10 see R15
      end else begin
        page_perm = 1'b1; // see R9
      end
    end
  end

  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < 32; i++) begin
      sum = sum + window[i];
    end
  end

  // expected checksum is the complement of the byte sum's low byte
  assign cksum_ok = (cmd_wdata == ~sum);
  assign commit = wr_ck && page_perm && !overflow && cksum_ok; // see R3 see R7 see R20 see R22

  // ----------------------------------------------------------------
  // command-space setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      subclass <= 8'h00;
    end else if (wr_sub && (level != SIB_SEALED)) begin
      subclass <= cmd_wdata; // see R9
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      block_code <= 8'h00;
    end else if (wr_blk) begin
      block_code <= cmd_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      selector <= `SIB_SEL_GENERAL;
    end else if (wr_sel && (level != SIB_SEALED)) begin
      selector <= cmd_wdata; // see R19
    end
  end

  // ----------------------------------------------------------------
  // window: load on block select, edit byte by byte
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      page <= 10'h000;
      page_valid <= 1'b0;
    end else if (wr_blk) begin
      page <= next_page;
      page_valid <= load_ok;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        window[i] <= 8'h00;
      end
    end else if (load_ok) begin
      for (int i = 0; i < 32; i++) begin
        window[i] <= rd_row[i*8 +: 8]; // see R6
      end
    end else if (wr_win && page_perm && !overflow && (wr_count < `SIB_BLOCK_BYTES)) begin
      // bytes past the 32nd never land in the window
      window[win_idx] <= cmd_wdata; // see R8 see R20
    end
  end

  // a failed commit leaves the window as it was so the host may retry
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_count <= 6'h00;
    end else if (load_ok || commit) begin
      wr_count <= 6'h00;
    end else if (wr_win && !overflow) begin
      wr_count <= wr_count + 6'h01; // see R20 see R22
    end
  end

  // ----------------------------------------------------------------
  // control port: two bytes form one word
  // ----------------------------------------------------------------
  logic ctl_valid;
  logic [15:0] ctl_word;
  logic unseal_match;
  logic full_match;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctl_lo <= 8'h00;
    end else if (wr_ctl_lo) begin
      ctl_lo <= cmd_wdata;
    end
  end

  assign ctl_valid = wr_ctl_hi;
  assign ctl_word = {cmd_wdata, ctl_lo};

  // key word 1 must come first and word 0 directly after it
  sib_keychk u_unseal_chk (
    .mclk(mclk),
    .reset_n(reset_n),
    .word_valid(ctl_valid),
    .word(ctl_word),
    .key_first(unseal_k1),
    .key_second(unseal_k0),
    .match(unseal_match)
  ); // see R11 see R16 see R21

  sib_keychk u_full_chk (
    .mclk(mclk),
    .reset_n(reset_n),
    .word_valid(ctl_valid),
    .word(ctl_word),
    .key_first(full_k1),
    .key_second(full_k0),
    .match(full_match)
  ); // see R11 see R16 see R21

  // ----------------------------------------------------------------
  // security level and status flags
  // ----------------------------------------------------------------
  // a seal subcommand wins over a key match in the same word; keys are
  // required to differ from subcommands, so the two never meet in practice
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      level <= SIB_SEALED;
    end else if (ctl_valid && (ctl_word == `SIB_CMD_SEAL)) begin
      level <= SIB_SEALED; // see R12
    end else if (unseal_match && (level == SIB_SEALED)) begin
      level <= SIB_OPEN; // see R13
    end else if (full_match && (level == SIB_OPEN)) begin
      level <= SIB_FULL; // see R14
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sealed_flag <= 1'b1;
      full_access_flag <= 1'b1;
    end else if (ctl_valid && (ctl_word == `SIB_CMD_SEAL)) begin
      sealed_flag <= 1'b1;
      full_access_flag <= 1'b1;
    end else if (unseal_match && (level == SIB_SEALED)) begin
      sealed_flag <= 1'b0; // see R13 see R21
    end else if (full_match && (level == SIB_OPEN)) begin
      full_access_flag <= 1'b0; // see R14 see R21
    end
  end

  assign security_level = level;

  // ----------------------------------------------------------------
  // commit outcome
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      commit_pulse <= 1'b0;
      reject_pulse <= 1'b0;
    end else begin
      commit_pulse <= commit; // see R3
      reject_pulse <= wr_ck && !commit; // see R22
    end
  end

  // ----------------------------------------------------------------
  // read path, one cycle latency
  // ----------------------------------------------------------------
  logic [15:0] status_word;

  always_comb begin
    status_word = 16'h0000;
    status_word[`SIB_STAT_SEALED] = sealed_flag;
    status_word[`SIB_STAT_FULL] = full_access_flag;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmd_rdata <= 8'h00;
    end else if (cmd_rd) begin
      if (rd_win) begin
        // window reads at every level keep info blocks readable
        cmd_rdata <= window[rd_idx]; // see R9
      end else begin
        case (cmd_addr)
          `SIB_ADDR_CTL_LO: begin
            cmd_rdata <= status_word[7:0];
          end
          `SIB_ADDR_CTL_HI: begin
            cmd_rdata <= status_word[15:8];
          end
          `SIB_ADDR_SUBCLASS: begin
            cmd_rdata <= subclass;
          end
          `SIB_ADDR_BLOCK: begin
            cmd_rdata <= block_code;
          end
          `SIB_ADDR_CKSUM: begin
            cmd_rdata <= ~sum; // see R18
          end
          `SIB_ADDR_SELECTOR: begin
            cmd_rdata <= selector;
          end
          default: begin
            cmd_rdata <= 8'h00;
          end
        endcase
      end
    end else begin
      cmd_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ---- test/sib_host.sv ----
// host model that drives the command port of the access block
`timescale 1ns/1ns
`default_nettype none
`include "sib_defs.svh"
module sib_host (
  input wire logic mclk, // system clock
  input wire logic [7:0] cmd_rdata, // read data from the device
  output logic [7:0] cmd_addr, // command code
  output logic [7:0] cmd_wdata, // write data
  output logic cmd_wr, // write strobe
  output logic cmd_rd // read strobe
);
  initial begin
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
  end
  // one access; address and data are inverted and strobes dropped on release so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= w;
    cmd_rd <= !w;
    @(posedge mclk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    cmd_addr <= ~a;
    cmd_wdata <= ~d;
    #1;
    q = cmd_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic ctl(input logic [15:0] w);
    wr(`SIB_ADDR_CTL_LO, w[7:0]);
    wr(`SIB_ADDR_CTL_HI, w[15:8]);
  endtask
  // key 1 then key 0, each byte-swapped, nothing in between
  task automatic key(input logic [15:0] k1, input logic [15:0] k0);
    ctl({k1[7:0], k1[15:8]});
    ctl({k0[7:0], k0[15:8]});
  endtask
  task automatic cksum(input logic [7:0] s);
    wr(`SIB_ADDR_CKSUM, 8'hff - s);
  endtask
endmodule
`default_nettype wire

// ---- test/sib_access_props.sv ----
// port checker for the information block access logic
`timescale 1ns/1ns
`default_nettype none
`include "sib_defs.svh"
module sib_access_props import sib_pkg::*; (
  input wire logic mclk, // system clock
  input wire logic reset_n, // reset, active low
  input wire logic [7:0] cmd_addr, // command code
  input wire logic [7:0] cmd_wdata, // write data
  input wire logic cmd_wr, // write strobe
  input wire logic cmd_rd, // read strobe
  input wire logic [7:0] cmd_rdata, // read data
  input wire sib_pkg::sib_level_t security_level, // level
  input wire logic sealed_flag, // sealed status
  input wire logic full_access_flag, // not full access
  input wire logic commit_pulse, // commit done
  input wire logic reject_pulse // checksum refused
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  reset_vals_a: assert property (disable iff (1'b0) !reset_n |=> security_level == SIB_SEALED && sealed_flag
    && full_access_flag && !commit_pulse && !reject_pulse && cmd_rdata == 8'h00) else $error("reset values wrong");
  rdata_idle_a: assert property (!cmd_rd |=> cmd_rdata == 8'h00) else $error("read data not idle");
  sealed_flag_a: assert property (sealed_flag == (security_level == SIB_SEALED)) else $error("sealed flag off");
  full_flag_a: assert property (full_access_flag == (security_level != SIB_FULL)) else $error("full flag off");
  status_read_a: assert property (cmd_rd && cmd_addr == `SIB_ADDR_CTL_HI |=>
    cmd_rdata[`SIB_STAT_SEALED - 8] == sealed_flag && cmd_rdata[`SIB_STAT_FULL - 8] == full_access_flag)
    else $error("status byte wrong");
  commit_cause_a: assert property (commit_pulse |-> $past(cmd_wr && cmd_addr == `SIB_ADDR_CKSUM))
    else $error("commit without checksum");
  reject_cause_a: assert property (reject_pulse |-> $past(cmd_wr && cmd_addr == `SIB_ADDR_CKSUM) && !commit_pulse)
    else $error("reject without checksum");
  level_cause_a: assert property ($changed(security_level) && $past(reset_n) |->
    $past(cmd_wr && cmd_addr == `SIB_ADDR_CTL_HI))
    else $error("level changed without key word");
  no_jump_a: assert property (security_level == SIB_SEALED |=> security_level != SIB_FULL)
    else $error("sealed went straight to full");
endmodule
bind sib_access sib_access_props i_props (.mclk(mclk), .reset_n(reset_n), .cmd_addr(cmd_addr),
  .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
  .security_level(security_level), .sealed_flag(sealed_flag), .full_access_flag(full_access_flag),
  .commit_pulse(commit_pulse), .reject_pulse(reject_pulse));
`default_nettype wire

// ---- test/sib_access_tb.sv ----
// self-checking bench for the information block access logic
`timescale 1ns/1ns
`default_nettype none
`include "sib_defs.svh"
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end \
end
module sib_access_tb;
  import sib_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d;} sib_row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] cmd_addr, cmd_wdata, cmd_rdata;
  logic cmd_wr, cmd_rd, sealed_flag, full_access_flag, commit_pulse, reject_pulse;
  sib_level_t security_level;
  int checks = 0;
  int n_mismatch = 0;
  // reads carry the expected byte in d; storage starts all zero apart from the key page
  sib_row_t rows [12] = '{'{0, 8'h01, 8'h60}, '{1, 8'h3f, 8'h01}, '{0, 8'h40, 8'h00}, '{0, 8'h3f, 8'h01},
    '{1, 8'h3f, 8'h03}, '{0, 8'h5f, 8'h00}, '{0, 8'h60, 8'hff}, '{1, 8'h61, 8'h01}, '{0, 8'h61, 8'h00},
    '{0, 8'h7a, 8'h00}, '{1, 8'h3f, 8'h02}, '{0, 8'h40, 8'h00}};
  always #50 mclk = ~mclk;
  sib_host i_host (.mclk(mclk), .cmd_rdata(cmd_rdata), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd));
  sib_access i_dut (.mclk(mclk), .reset_n(reset_n), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .security_level(security_level),
    .sealed_flag(sealed_flag), .full_access_flag(full_access_flag), .commit_pulse(commit_pulse),
    .reject_pulse(reject_pulse));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_host.xfer(1'b0, a, 8'h00, q);
    `CHK("read data", e, q)
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    logic [7:0] q;
    logic [7:0] s;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    // ----------------------------------------
    // table of sealed-level accesses
    // ----------------------------------------
    foreach (rows[i]) begin
      i_host.xfer(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) `CHK("row read", rows[i].d, q)
    end
    // ----------------------------------------
    // hand-written cases
    // ----------------------------------------
    s = 8'h00;
    for (int i = 0; i < 32; i++) begin
      i_host.wr(8'h40 + 8'(i), 8'(i + 1));
      s += 8'(i + 1);
    end
    i_host.cksum(s);
    `CHK("commit", 1'b1, commit_pulse)
    i_host.wr(8'h3f, 8'h01);
    i_host.wr(8'h40, 8'haa);
    rdc(8'h40, 8'h00);
    i_host.wr(8'h3f, 8'h02);
    rdc(8'h45, 8'h06);
    i_host.wr(8'h40, 8'h55);
    i_host.wr(8'h60, 8'h00);
    `CHK("reject", 1'b1, reject_pulse)
    rdc(8'h40, 8'h55);
    i_host.wr(8'h3f, 8'h02);
    rdc(8'h40, 8'h01);
    // a wrong, interrupted or unswapped key pair leaves the level sealed
    i_host.key(`SIB_DEF_UNSEAL_K1, 16'h1234);
    `CHK("level", SIB_SEALED, security_level)
    i_host.key(`SIB_DEF_FULL_K1, `SIB_DEF_FULL_K0);
    `CHK("level", SIB_SEALED, security_level)
    i_host.ctl(16'h1404);
    i_host.ctl(16'h0001);
    i_host.ctl(16'h7236);
    `CHK("level", SIB_SEALED, security_level)
    i_host.ctl(`SIB_DEF_UNSEAL_K1);
    i_host.ctl(`SIB_DEF_UNSEAL_K0);
    `CHK("level", SIB_SEALED, security_level)
    i_host.key(`SIB_DEF_UNSEAL_K1, `SIB_DEF_UNSEAL_K0);
    `CHK("level", SIB_OPEN, security_level)
    `CHK("sealed flag", 1'b0, sealed_flag)
    i_host.wr(8'h61, 8'h00);
    i_host.wr(8'h3e, 8'h39);
    i_host.wr(8'h3f, 8'h01);
    rdc(8'h40, 8'h01);
    rdc(8'h5f, 8'h20);
    for (int i = 0; i < 33; i++)
      i_host.wr(8'h40 + 8'(i % 32), 8'h00);
    i_host.cksum(8'h00);
    `CHK("overflow commit", 1'b0, commit_pulse)
    i_host.wr(8'h3e, 8'h70);
    i_host.wr(8'h3f, 8'h00);
    i_host.wr(8'h40, 8'h12);
    rdc(8'h40, 8'h04);
    i_host.key(`SIB_DEF_FULL_K1, `SIB_DEF_FULL_K0);
    `CHK("level", SIB_FULL, security_level)
    `CHK("full flag", 1'b0, full_access_flag)
    i_host.wr(8'h40, 8'h12);
    rdc(8'h40, 8'h12);
    i_host.ctl(`SIB_CMD_SEAL);
    `CHK("level", SIB_SEALED, security_level)
    i_host.key(`SIB_DEF_UNSEAL_K1, `SIB_DEF_UNSEAL_K0);
    `CHK("level", SIB_OPEN, security_level)
    i_host.wr(8'h61, 8'h01);
    rdc(8'h61, 8'h01);
    i_host.wr(8'h3f, 8'h02);
    rdc(8'h40, 8'h01);
    i_host.wr(8'h3f, 8'h01);
    i_host.wr(8'h40, 8'h77);
    rdc(8'h40, 8'h77);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    `CHK("level", SIB_SEALED, security_level)
    rdc(8'h61, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
